// ### hdl/hpb_pkg.sv
package hpb_pkg;
  // ****************************************
  // Command bytes
  // ****************************************
  localparam logic [7:0] CMD_SLOT_B_CONTROL = 8'h03;
  localparam logic [7:0] CMD_SLOT_B_STATUS = 8'h05;
  localparam logic [7:0] CMD_SHARED_STATUS = 8'h06;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SLOT_B_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SHARED_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int CTL_AUX_ENABLE = 0;
  localparam int CTL_MAIN_ENABLE = 1;
  localparam int CTL_FORCE_GATE = 2;
  localparam int CTL_MAIN_PG = 6;
  localparam int CTL_AUX_PG = 7;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int ST_3V3_OC = 0;
  localparam int ST_12V_OC = 2;
  localparam int ST_AUX_OC = 4;
  localparam int ST_AUX_ON = 5;
  localparam int ST_MAIN_ON = 6;
  localparam int ST_FAULT = 7;
  // ****************************************
  // Shared fields
  // ****************************************
  localparam int SH_OVERTEMP = 1;
  localparam int SH_UNDERVOLT = 2;
  localparam int SH_IRQ_MASK = 3;
  localparam int SH_GEN_A = 4;
  localparam int SH_GEN_B = 5;
endpackage

// ### hdl/hpb_sticky.sv
`timescale 1ns/100ps
// Sticky flag, set wins over write-one-to-clear
module hpb_sticky (
  input wire logic clk,
  input wire logic rstn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

// ### hdl/hpb_fault_latch.sv
`timescale 1ns/100ps
// Fault latch: each cause held until its own enable input drops or active goes low
module hpb_fault_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic main_oc,
  input wire logic aux_oc,
  input wire logic main_on,
  input wire logic aux_req,
  input wire logic active,
  output logic fault
);
  logic main_hold;
  logic aux_hold;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_hold <= 1'b0;
    end else if (!active || !main_on) begin
      main_hold <= 1'b0;
    end else if (main_oc) begin
      main_hold <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aux_hold <= 1'b0;
    end else if (!active || !aux_req) begin
      aux_hold <= 1'b0;
    end else if (aux_oc) begin
      aux_hold <= 1'b1;
    end
  end
  assign fault = main_hold | aux_hold;
endmodule

// ### hdl/hpb_regs.sv
`timescale 1ns/100ps
// Operation
// RL1: Control bits enable main and aux supplies
// RL2: Control bit 2 gates force-on input
// RL3: Control bits 7,6 report power good
// RL4: Control register resets to all zeros
// RL5: Power-good pin ANDs bits unless forced
// RL6: Power-good bits ignore force-on input
// RL7: Status bit 7 shows fault asserted
// RL8: Status bits 6,5 show actual outputs
// RL9: Sticky overcurrent flags bits 4,2,0
// RL10: Write one clears overcurrent flag
// RL11: Reads and clears leave fault pin
// RL12: Fault clears when matching enable drops
// RL13: Serial control keeps fault inactive
// RL14: System ties enable inputs low then
// RL15: Force-on low releases fault pin
// RL16: Shared bits 5,4 mirror general inputs
// RL17: Shared bit 3 masks interrupt
// RL18: No alert response address support
// RL19: Undervolt flag only when slot enabled
// RL20: Over-temperature detector sets bit 1
// RL21: Undervolt, overtemp cleared by writing one
// RL22: Interrupt asserts on unmasked set flag
// RL23: Read-only writes ignored, reserved zero
module hpb_regs (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic WR_STB,
  input wire logic [7:0] WR_CMD,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_CMD,
  output logic [7:0] RD_DATA,
  input wire logic SLOT_B_MAIN_PG_IN,
  input wire logic SLOT_B_AUX_PG_IN,
  input wire logic SLOT_B_MAIN_IS_ON,
  input wire logic SLOT_B_AUX_IS_ON,
  input wire logic SLOT_B_3V3_OC_EVT,
  input wire logic SLOT_B_12V_OC_EVT,
  input wire logic SLOT_B_AUX_OC_EVT,
  input wire logic SLOT_B_MAIN_ON_INPUT,
  input wire logic SLOT_B_AUX_REQUEST_INPUT,
  input wire logic SLOT_B_FORCE_ON_INPUT_N,
  input wire logic SERIAL_MGMT_CONTROL,
  input wire logic SLOT_B_GEN_INPUT,
  input wire logic SLOT_A_GEN_INPUT,
  input wire logic UNDERVOLTAGE_LOCKOUT,
  input wire logic OVERTEMP_DETECT,
  output logic SLOT_B_MAIN_ENABLE,
  output logic SLOT_B_AUX_ENABLE,
  output logic SLOT_B_POWER_GOOD_PIN_OE_N,
  output logic SLOT_B_FAULT_INDICATOR_OE_N,
  output logic IRQ_N
);
  // ****************************************
  // Write decode
  // ****************************************
  // One strobe per register; unmapped commands hit nothing and are dropped
  function automatic logic cmd_hit(input logic stb, input logic [7:0] cmd,
    input logic [7:0] target);
    cmd_hit = stb && (cmd == target);
  endfunction

  // Write-one-to-clear: a zero in the data leaves the flag alone
  function automatic logic w1c(input logic hit, input logic [7:0] data, input int pos);
    w1c = hit && data[pos];
  endfunction

  logic wr_ctl;
  logic wr_st;
  logic wr_sh;
  assign wr_ctl = cmd_hit(WR_STB, WR_CMD, hpb_pkg::CMD_SLOT_B_CONTROL);
  assign wr_st = cmd_hit(WR_STB, WR_CMD, hpb_pkg::CMD_SLOT_B_STATUS);
  assign wr_sh = cmd_hit(WR_STB, WR_CMD, hpb_pkg::CMD_SHARED_STATUS);

  logic clr_3v3;
  logic clr_12v;
  logic clr_aux;
  logic clr_uv;
  logic clr_ot;
  assign clr_3v3 = w1c(wr_st, WR_DATA, hpb_pkg::ST_3V3_OC); // [RL10]
  assign clr_12v = w1c(wr_st, WR_DATA, hpb_pkg::ST_12V_OC); // [RL10]
  assign clr_aux = w1c(wr_st, WR_DATA, hpb_pkg::ST_AUX_OC); // [RL10]
  assign clr_uv = w1c(wr_sh, WR_DATA, hpb_pkg::SH_UNDERVOLT); // [RL21]
  assign clr_ot = w1c(wr_sh, WR_DATA, hpb_pkg::SH_OVERTEMP); // [RL21]

  // ****************************************
  // Control register
  // ****************************************
  logic main_en;
  logic aux_en;
  logic force_gate;
  logic fault;
  logic fault_main_kill;

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      main_en <= hpb_pkg::SLOT_B_CONTROL_RESET[hpb_pkg::CTL_MAIN_ENABLE]; // [RL4]
    end else if (wr_ctl) begin
      main_en <= WR_DATA[hpb_pkg::CTL_MAIN_ENABLE]; // [RL1]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      aux_en <= hpb_pkg::SLOT_B_CONTROL_RESET[hpb_pkg::CTL_AUX_ENABLE]; // [RL4]
    end else if (wr_ctl) begin
      aux_en <= WR_DATA[hpb_pkg::CTL_AUX_ENABLE]; // [RL1]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      force_gate <= hpb_pkg::SLOT_B_CONTROL_RESET[hpb_pkg::CTL_FORCE_GATE]; // [RL4]
    end else if (wr_ctl) begin
      force_gate <= WR_DATA[hpb_pkg::CTL_FORCE_GATE]; // [RL2]
    end
  end

  // Supplies on from register or from hardware request pins
  // A latched fault blocks only the request pins; register enables still act
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SLOT_B_MAIN_ENABLE <= 1'b0;
    end else begin
      SLOT_B_MAIN_ENABLE <= main_en | (SLOT_B_MAIN_ON_INPUT & ~fault_main_kill); // [RL1]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SLOT_B_AUX_ENABLE <= 1'b0;
    end else begin
      SLOT_B_AUX_ENABLE <= aux_en | (SLOT_B_AUX_REQUEST_INPUT & ~fault_main_kill); // [RL1]
    end
  end

  // ****************************************
  // Overcurrent flags
  // ****************************************
  logic oc_3v3;
  logic oc_12v;
  logic oc_aux;
  hpb_sticky u_oc_3v3 (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .set(SLOT_B_3V3_OC_EVT), // [RL9]
    .clr(clr_3v3), // [RL10]
    .flag(oc_3v3)
  );
  hpb_sticky u_oc_12v (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .set(SLOT_B_12V_OC_EVT), // [RL9]
    .clr(clr_12v), // [RL10]
    .flag(oc_12v)
  );
  hpb_sticky u_oc_aux (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .set(SLOT_B_AUX_OC_EVT), // [RL9]
    .clr(clr_aux), // [RL10]
    .flag(oc_aux)
  );

  // ****************************************
  // Fault state
  // ****************************************
  // Fault latch is independent of the flags, so clearing them leaves the pin
  hpb_fault_latch u_fault (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .main_oc(SLOT_B_3V3_OC_EVT | SLOT_B_12V_OC_EVT),
    .aux_oc(SLOT_B_AUX_OC_EVT),
    .main_on(SLOT_B_MAIN_ON_INPUT), // [RL12]
    .aux_req(SLOT_B_AUX_REQUEST_INPUT), // [RL12]
    .active(~SERIAL_MGMT_CONTROL), // [RL13]
    .fault(fault)
  ); // [RL11]
  assign fault_main_kill = fault;

  // ****************************************
  // Shared register
  // ****************************************
  logic irq_mask;
  logic uv_flag;
  logic ot_flag;
  logic uv_set;
  // Lockout only counts while the slot is meant to be powered
  assign uv_set = UNDERVOLTAGE_LOCKOUT & (SLOT_B_MAIN_ON_INPUT | main_en); // [RL19]
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask <= hpb_pkg::SHARED_RESET[hpb_pkg::SH_IRQ_MASK];
    end else if (wr_sh) begin
      irq_mask <= WR_DATA[hpb_pkg::SH_IRQ_MASK]; // [RL17]
    end
  end
  hpb_sticky u_uv (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .set(uv_set), // [RL19]
    .clr(clr_uv), // [RL21]
    .flag(uv_flag)
  );
  hpb_sticky u_ot (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .set(OVERTEMP_DETECT), // [RL20]
    .clr(clr_ot), // [RL21]
    .flag(ot_flag)
  );

  // ****************************************
  // Pins
  // ****************************************
  logic force_active;
  logic pg_both;
  logic irq_src;
  assign force_active = ~SLOT_B_FORCE_ON_INPUT_N & ~force_gate; // [RL2]
  assign pg_both = SLOT_B_MAIN_PG_IN & SLOT_B_AUX_PG_IN; // [RL5]
  assign irq_src = oc_3v3 | oc_12v | oc_aux | uv_flag | ot_flag; // [RL22]

  // Open drain: driving low means not good; released means good
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SLOT_B_POWER_GOOD_PIN_OE_N <= 1'b1;
    end else begin
      SLOT_B_POWER_GOOD_PIN_OE_N <= pg_both & ~force_active; // [RL5]
    end
  end

  // Fault drives low; force-on low releases it regardless of gate
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      SLOT_B_FAULT_INDICATOR_OE_N <= 1'b1;
    end else begin
      SLOT_B_FAULT_INDICATOR_OE_N <= ~(fault & SLOT_B_FORCE_ON_INPUT_N); // [RL15] [RL13]
    end
  end

  // Mask gates only the pin; flags keep collecting while masked
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      IRQ_N <= 1'b1;
    end else begin
      IRQ_N <= ~(irq_src & ~irq_mask); // [RL22] [RL17]
    end
  end

  // ****************************************
  // Read views
  // ****************************************
  logic [7:0] ctl_view;
  logic [7:0] st_view;
  logic [7:0] sh_view;
  // Unlisted bits stay zero, which covers every reserved position [RL23]
  always_comb begin
    ctl_view = hpb_pkg::UNMAPPED_READ;
    ctl_view[hpb_pkg::CTL_AUX_PG] = SLOT_B_AUX_PG_IN; // [RL3] [RL6]
    ctl_view[hpb_pkg::CTL_MAIN_PG] = SLOT_B_MAIN_PG_IN; // [RL3] [RL6]
    ctl_view[hpb_pkg::CTL_FORCE_GATE] = force_gate;
    ctl_view[hpb_pkg::CTL_MAIN_ENABLE] = main_en;
    ctl_view[hpb_pkg::CTL_AUX_ENABLE] = aux_en;
  end
  always_comb begin
    st_view = hpb_pkg::UNMAPPED_READ;
    st_view[hpb_pkg::ST_FAULT] = fault; // [RL7] [RL13]
    st_view[hpb_pkg::ST_MAIN_ON] = SLOT_B_MAIN_IS_ON; // [RL8]
    st_view[hpb_pkg::ST_AUX_ON] = SLOT_B_AUX_IS_ON; // [RL8]
    st_view[hpb_pkg::ST_AUX_OC] = oc_aux; // [RL9]
    st_view[hpb_pkg::ST_12V_OC] = oc_12v; // [RL9]
    st_view[hpb_pkg::ST_3V3_OC] = oc_3v3; // [RL9]
  end
  always_comb begin
    sh_view = hpb_pkg::UNMAPPED_READ;
    sh_view[hpb_pkg::SH_GEN_B] = SLOT_B_GEN_INPUT; // [RL16]
    sh_view[hpb_pkg::SH_GEN_A] = SLOT_A_GEN_INPUT; // [RL16]
    sh_view[hpb_pkg::SH_IRQ_MASK] = irq_mask;
    sh_view[hpb_pkg::SH_UNDERVOLT] = uv_flag;
    sh_view[hpb_pkg::SH_OVERTEMP] = ot_flag;
  end

  // ****************************************
  // Read mux
  // ****************************************
  // No alert response address: host polls these registers [RL18]
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      RD_DATA <= hpb_pkg::UNMAPPED_READ;
    end else begin
      case (RD_CMD)
        hpb_pkg::CMD_SLOT_B_CONTROL: begin
          RD_DATA <= ctl_view;
        end
        hpb_pkg::CMD_SLOT_B_STATUS: begin
          RD_DATA <= st_view;
        end
        hpb_pkg::CMD_SHARED_STATUS: begin
          RD_DATA <= sh_view;
        end
        default: begin
          RD_DATA <= hpb_pkg::UNMAPPED_READ; // [RL23]
        end
      endcase
    end
  end
endmodule

// ### sim/hpb_regs_asserts.sv
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module hpb_chk (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic WR_STB,
  input wire logic [7:0] WR_CMD,
  input wire logic [7:0] WR_DATA,
  input wire logic [7:0] RD_CMD,
  input wire logic [7:0] RD_DATA,
  input wire logic SLOT_B_MAIN_PG_IN,
  input wire logic SLOT_B_AUX_PG_IN,
  input wire logic SLOT_B_FORCE_ON_INPUT_N,
  input wire logic SERIAL_MGMT_CONTROL,
  input wire logic SLOT_B_POWER_GOOD_PIN_OE_N,
  input wire logic SLOT_B_FAULT_INDICATOR_OE_N,
  input wire logic IRQ_N
);
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  sequence s_mask_wr;
    WR_STB && WR_CMD == 8'h06 && WR_DATA[3];
  endsequence
  sequence s_no_sh_wr;
    !(WR_STB && WR_CMD == 8'h06);
  endsequence
  property p_pg_bad;
    !(SLOT_B_MAIN_PG_IN && SLOT_B_AUX_PG_IN) |=> !SLOT_B_POWER_GOOD_PIN_OE_N;
  endproperty
  property p_pg_good;
    SLOT_B_MAIN_PG_IN && SLOT_B_AUX_PG_IN && SLOT_B_FORCE_ON_INPUT_N |=> SLOT_B_POWER_GOOD_PIN_OE_N;
  endproperty
  property p_flt_force;
    !SLOT_B_FORCE_ON_INPUT_N |=> SLOT_B_FAULT_INDICATOR_OE_N;
  endproperty
  // Two cycles of settling before the pin must be released
  property p_flt_smc;
    SERIAL_MGMT_CONTROL [*3] |-> SLOT_B_FAULT_INDICATOR_OE_N;
  endproperty
  property p_rd_none;
    !(RD_CMD inside {8'h03, 8'h05, 8'h06}) |=> RD_DATA == 8'h00;
  endproperty
  property p_rd_ctl;
    RD_CMD == 8'h03 |=> RD_DATA[5:3] == 3'h0;
  endproperty
  property p_rd_st;
    RD_CMD == 8'h05 |=> RD_DATA[3] == 1'b0 && RD_DATA[1] == 1'b0;
  endproperty
  property p_irq_mask;
    s_mask_wr ##1 s_no_sh_wr [*2] |-> IRQ_N;
  endproperty
  a_pg_bad: assert property (p_pg_bad) else $error("pg pin released while bad");
  a_pg_good: assert property (p_pg_good) else $error("pg pin low while good");
  a_flt_force: assert property (p_flt_force) else $error("fault pin not released");
  a_flt_smc: assert property (p_flt_smc) else $error("fault pin active under serial");
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
  a_rd_ctl: assert property (p_rd_ctl) else $error("control reserved bits set");
  a_rd_st: assert property (p_rd_st) else $error("status reserved bits set");
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt asserted");
endmodule

bind hpb_regs hpb_chk u_chk (.CLK_SYS, .RSTN, .WR_STB, .WR_CMD, .WR_DATA, .RD_CMD, .RD_DATA,
  .SLOT_B_MAIN_PG_IN, .SLOT_B_AUX_PG_IN, .SLOT_B_FORCE_ON_INPUT_N, .SERIAL_MGMT_CONTROL,
  .SLOT_B_POWER_GOOD_PIN_OE_N, .SLOT_B_FAULT_INDICATOR_OE_N, .IRQ_N);

// ### sim/hpb_host.sv
`timescale 1ns/100ps
// ****************************************
// Serial management host model
// ****************************************
module hpb_host (
  input wire logic clk,
  output logic stb,
  output logic [7:0] cmd,
  output logic [7:0] data,
  output logic [7:0] rcmd,
  input wire logic [7:0] rdata
);
  initial begin
    stb = 1'b0;
    cmd = 8'h00;
    data = 8'h00;
    rcmd = 8'h00;
  end
  // Flags are cleared by sending ones in their places
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk);
    stb <= 1'b1;
    cmd <= c;
    data <= d;
    @(posedge clk);
    stb <= 1'b0;
  endtask
  // Alert response is never used: the source is found by reading
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    @(posedge clk);
    rcmd <= c;
    repeat (2) @(posedge clk);
    #1;
    d = rdata;
  endtask
endmodule

// ### sim/tb_hot_plug_slot_b_status_regs.sv
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_hot_plug_slot_b_status_regs;
  logic clk, rstn, mon, areq, fon_n, smc, wr_stb, men, aen, pg_oe_n, flt_oe_n, irq_n;
  logic [4:0] evt;
  logic [1:0] pg, ison, gen;
  logic [7:0] rd_cmd, rd_data, wr_cmd, wr_data, v;
  int err_total = 0;
  int cmp_count = 0;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  hpb_regs u_dut (.CLK_SYS(clk), .RSTN(rstn), .WR_STB(wr_stb), .WR_CMD(wr_cmd),
    .WR_DATA(wr_data), .RD_CMD(rd_cmd), .RD_DATA(rd_data), .SLOT_B_MAIN_PG_IN(pg[0]),
    .SLOT_B_AUX_PG_IN(pg[1]), .SLOT_B_MAIN_IS_ON(ison[1]), .SLOT_B_AUX_IS_ON(ison[0]),
    .SLOT_B_3V3_OC_EVT(evt[0]), .SLOT_B_12V_OC_EVT(evt[1]), .SLOT_B_AUX_OC_EVT(evt[2]),
    .SLOT_B_MAIN_ON_INPUT(mon), .SLOT_B_AUX_REQUEST_INPUT(areq),
    .SLOT_B_FORCE_ON_INPUT_N(fon_n), .SERIAL_MGMT_CONTROL(smc), .SLOT_B_GEN_INPUT(gen[1]),
    .SLOT_A_GEN_INPUT(gen[0]), .UNDERVOLTAGE_LOCKOUT(evt[3]), .OVERTEMP_DETECT(evt[4]),
    .SLOT_B_MAIN_ENABLE(men), .SLOT_B_AUX_ENABLE(aen), .SLOT_B_POWER_GOOD_PIN_OE_N(pg_oe_n),
    .SLOT_B_FAULT_INDICATOR_OE_N(flt_oe_n), .IRQ_N(irq_n));
  hpb_host u_host (.clk(clk), .stb(wr_stb), .cmd(wr_cmd), .data(wr_data), .rcmd(rd_cmd),
    .rdata(rd_data));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic rc(input logic [7:0] c, input logic [7:0] e);
    u_host.rd(c, v);
    `CHK("read", e, v)
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= 5'h00;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rc(8'h03, 8'h00);
    rc(8'h05, 8'h00);
    rc(8'h06, 8'h00);
    `CHK("supply_en", 2'b00, {men, aen})
  endtask
  task automatic t_stat;
    @(posedge clk);
    ison <= 2'b11;
    mon <= 1'b1;
    areq <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK("req_en", 2'b11, {men, aen})
    ev(5'h07);
    rc(8'h05, 8'hf5);
    `CHK("req_en", 2'b00, {men, aen})
    `CHK("fault_pin", 1'b0, flt_oe_n)
    `CHK("irq", 1'b0, irq_n)
    u_host.wr(8'h05, 8'h15);
    rc(8'h05, 8'he0);
    `CHK("fault_pin", 1'b0, flt_oe_n)
    `CHK("irq", 1'b1, irq_n)
    @(posedge clk);
    fon_n <= 1'b0;
    areq <= 1'b0;
    rc(8'h05, 8'he0);
    `CHK("fault_pin", 1'b1, flt_oe_n)
    @(posedge clk);
    fon_n <= 1'b1;
    mon <= 1'b0;
    u_host.wr(8'h05, 8'hff);
    rc(8'h05, 8'h60);
    `CHK("fault_pin", 1'b1, flt_oe_n)
    @(posedge clk);
    smc <= 1'b1;
    ev(5'h01);
    u_host.rd(8'h05, v);
    `CHK("fault_bit", 1'b0, v[7])
    `CHK("fault_pin", 1'b1, flt_oe_n)
    `CHK("oc_3v3", 1'b1, v[0])
    u_host.wr(8'h05, 8'h01);
    @(posedge clk);
    smc <= 1'b0;
  endtask
  task automatic t_sh;
    @(posedge clk);
    gen <= 2'b10;
    ev(5'h08);
    rc(8'h06, 8'h20);
    u_host.wr(8'h03, 8'h02);
    ev(5'h18);
    rc(8'h06, 8'h26);
    `CHK("irq", 1'b0, irq_n)
    u_host.wr(8'h06, 8'h08);
    rc(8'h06, 8'h2e);
    `CHK("irq", 1'b1, irq_n)
    u_host.wr(8'h06, 8'hc7);
    rc(8'h06, 8'h20);
    @(posedge clk);
    gen <= 2'b01;
    rc(8'h06, 8'h10);
    u_host.wr(8'h07, 8'hff);
    rc(8'h07, 8'h00);
    rc(8'h03, 8'h02);
  endtask
  task automatic t_ctl;
    u_host.wr(8'h03, 8'hff);
    rc(8'h03, 8'h07);
    `CHK("supply_en", 2'b11, {men, aen})
    @(posedge clk);
    pg <= 2'b11;
    fon_n <= 1'b0;
    rc(8'h03, 8'hc7);
    `CHK("pg_pin", 1'b1, pg_oe_n)
    u_host.wr(8'h03, 8'h03);
    rc(8'h03, 8'hc3);
    `CHK("pg_pin", 1'b0, pg_oe_n)
    @(posedge clk);
    fon_n <= 1'b1;
    rc(8'h03, 8'hc3);
    `CHK("pg_pin", 1'b1, pg_oe_n)
    @(posedge clk);
    pg <= 2'b01;
    rc(8'h03, 8'h43);
    `CHK("pg_pin", 1'b0, pg_oe_n)
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    {rstn, mon, areq, smc, evt, pg, ison, gen} = '0;
    fon_n = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_stat();
    t_sh();
    t_ctl();
    end_of_test();
  end
  // The sequence needs about a hundred cycles; forty times that means a hang
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
